// ===== src/dhi_host.sv
// host-side controller driving the display module pins from APB registers
// What this block does
// [R01] The mode register picks serial, I2C, 6800 or 8080 at 8 or 4 bits, and codes 001/011 are never driven.
// [R02] The straps are driven as steady levels that change only while no transfer runs.
// [R03] In parallel modes the data port (all 8 lines, or only the upper four in 4-bit modes) is driven on writes and released and sampled on reads.
// [R04] In serial mode data goes out on data line 1 and the clock on data line 0.
// [R05] In I2C mode data line 2 and 1 are joined on the board, but no command starts, so line 0 is never driven as the I2C clock.
// [R06] The read strobe pin is the high enable in 6800 modes and the low read strobe in 8080 modes.
// [R07] In 6800 modes the direction line is high for a read and low for a write.
// [R08] In 8080 modes the direction line is a separate low write strobe.
// [R09] In serial mode the direction line is held low.
// [R10] The data/command line is high for display data and low for a command byte.
// [R11] The module reset output is held low while software asks for reset.
// [R12] Chip select is low only during a transfer.
// [R13] After module reset the device comes up in its default state, so software must reinitialise it.
// [R14] In 4-bit modes each byte goes as two nibbles, high first, on the upper four data lines.
module dhi_host
	import dhi_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             host_if_strap_0,
	output logic             host_if_strap_1,
	output logic             host_if_strap_2,
	input  wire logic [7:0]  bus_in,
	output logic      [7:0]  bus_out,
	output logic      [7:0]  bus_oe_n,
	output logic             rd_pin,
	output logic             rw_pin,
	output logic             data_command_select,
	output logic             module_reset_n,
	output logic             cs_n
);
	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_ACTIVE, ST_RECOVER, ST_SER} dhi_state_e;

	dhi_state_e  state_q;
	logic [2:0]  mode_q;
	logic        rst_req_q;
	logic [7:0]  byte_q;
	logic        dc_q;
	logic        rd_q;
	logic        nib_q;
	logic [3:0]  bit_q;
	logic        bad_q;
	logic        done_q;
	logic [7:0]  rdata_q;
	logic        tload;
	logic [CNT_W-1:0] tcount;
	logic        texp;

	wire is_par  = mode_q[2];
	wire is_4bit = mode_q[2] && mode_q[0];
	wire is_80   = mode_q[2] && mode_q[1];
	wire busy    = (state_q != ST_IDLE);
	wire wr_acc  = psel && penable && pwrite;
	wire cmd_go  = wr_acc && (paddr == REG_CMD) && !busy && !rst_req_q;

	dhi_phase_timer #(.W(CNT_W)) u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.load    (tload),
		.count   (tcount),
		.expired (texp)
	);

	// apb answers in the access phase with no wait state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= psel && !penable;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pslverr <= 1'b0;
		else
			pslverr <= psel && !penable && paddr[1:0] != 2'h0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= SLV_ERR_NONE;
		else if (psel && !penable && !pwrite)
			unique case (paddr)
				REG_CTRL:   prdata <= {27'h0, rst_req_q, 1'b0, mode_q};
				REG_STATUS: prdata <= {29'h0, done_q, bad_q, busy};
				REG_RDATA:  prdata <= {24'h0, rdata_q};
				default:    prdata <= SLV_ERR_NONE;
			endcase
	end

	// mode and reset request change only while idle so straps stay static
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_q    <= CTRL_MODE_RST;
			rst_req_q <= 1'b1;
		end
		else if (wr_acc && paddr == REG_CTRL && !busy)
		begin
			rst_req_q <= pwdata[CTRL_RST_BIT]; // [R11] [R13]
			if (pwdata[CTRL_MODE_LSB +: 3] != MODE_BAD1 && pwdata[CTRL_MODE_LSB +: 3] != MODE_BAD3)
				mode_q <= pwdata[CTRL_MODE_LSB +: 3]; // [R01] [R02]
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			bad_q <= 1'b0;
		else if (wr_acc && paddr == REG_CTRL && !busy)
			bad_q <= (pwdata[CTRL_MODE_LSB +: 3] == MODE_BAD1)
				|| (pwdata[CTRL_MODE_LSB +: 3] == MODE_BAD3); // [R01]
	end

	// straps and reset straight from flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			host_if_strap_0 <= CTRL_MODE_RST[0];
			host_if_strap_1 <= CTRL_MODE_RST[1];
			host_if_strap_2 <= CTRL_MODE_RST[2];
			module_reset_n  <= 1'b0;
		end
		else
		begin
			host_if_strap_0 <= mode_q[0]; // [R02]
			host_if_strap_1 <= mode_q[1];
			host_if_strap_2 <= mode_q[2];
			module_reset_n  <= !rst_req_q; // [R11]
		end
	end

	// transfer sequencer; i2c mode is selected but no command starts a transfer in it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= ST_IDLE;
			byte_q  <= 8'h00;
			dc_q    <= 1'b0;
			rd_q    <= 1'b0;
			nib_q   <= 1'b0;
			bit_q   <= 4'h0;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
					if (cmd_go && mode_q != MODE_I2C)
					begin
						byte_q  <= pwdata[CMD_DATA_LSB +: 8];
						dc_q    <= pwdata[CMD_DC_BIT];
						rd_q    <= pwdata[CMD_RD_BIT] && is_par; // serial is write-only
						nib_q   <= 1'b0;
						bit_q   <= 4'h0;
						state_q <= is_par ? ST_SETUP : ST_SER;
					end
				ST_SETUP:
					if (texp)
						state_q <= ST_ACTIVE;
				ST_ACTIVE:
					if (texp)
						state_q <= ST_RECOVER;
				ST_RECOVER:
					if (texp)
					begin
						if (is_4bit && !nib_q)
						begin
							nib_q   <= 1'b1; // [R14]
							state_q <= ST_SETUP;
						end
						else
							state_q <= ST_IDLE;
					end
				ST_SER:
					if (texp)
					begin
						if (bit_q == 4'hF)
							state_q <= ST_IDLE;
						bit_q <= bit_q + 4'h1;
					end
			endcase
		end
	end

	// phase timing
	always_comb
	begin
		tload  = 1'b0;
		tcount = CNT_W'(CYC_AS);
		unique case (state_q)
			ST_IDLE:
				tload = cmd_go;
			ST_SETUP:
			begin
				tload  = texp;
				tcount = rd_q ? CNT_W'(CYC_RDLO) : CNT_W'(CYC_CYCLE - CYC_WRHI - CYC_AS);
			end
			ST_ACTIVE:
			begin
				tload  = texp;
				tcount = rd_q ? CNT_W'(CYC_RDHI) : CNT_W'(CYC_WRHI);
			end
			ST_RECOVER:
				tload = texp && is_4bit && !nib_q;
			ST_SER:
			begin
				tload  = texp;
				tcount = CNT_W'(CYC_WRLO);
			end
		endcase
	end

	wire [7:0] out_byte = (is_4bit && nib_q) ? {byte_q[3:0], 4'h0} : byte_q; // [R14]
	wire       strobe   = (state_q == ST_ACTIVE);

	// pins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cs_n                <= 1'b1;
			rd_pin              <= 1'b0;
			rw_pin              <= 1'b0;
			data_command_select <= 1'b0;
			bus_out             <= 8'h00;
			bus_oe_n            <= 8'hFF;
		end
		else if (is_par)
		begin
			cs_n                <= !(state_q != ST_IDLE); // [R12]
			data_command_select <= dc_q; // [R10]
			bus_out             <= out_byte; // [R03]
			bus_oe_n            <= (busy && !rd_q) ? (is_4bit ? 8'h0F : 8'h00) : 8'hFF; // [R03]
			if (is_80)
			begin
				rd_pin <= !(strobe && rd_q); // [R06]
				rw_pin <= !(strobe && !rd_q); // [R08]
			end
			else
			begin
				rd_pin <= strobe; // [R06]
				rw_pin <= rd_q; // [R07]
			end
		end
		else
		begin
			cs_n                <= !(state_q == ST_SER); // [R12]
			rw_pin              <= 1'b0; // [R09]
			rd_pin              <= 1'b0;
			data_command_select <= dc_q; // [R10]
			bus_out             <= {6'h00, byte_q[3'(7 - bit_q[3:1])], bit_q[0]}; // [R04]
			bus_oe_n            <= (state_q == ST_SER) ? 8'hFC : 8'hFF; // [R04] [R05]
		end
	end

	// read capture at the end of the strobe, nibbles merged high first
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rdata_q <= 8'h00;
		else if (strobe && texp && rd_q)
		begin
			if (!is_4bit)
				rdata_q <= bus_in;
			else if (!nib_q)
				rdata_q[7:4] <= bus_in[7:4]; // [R14]
			else
				rdata_q[3:0] <= bus_in[7:4];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			done_q <= 1'b0;
		else if ((state_q == ST_RECOVER || state_q == ST_SER) && texp
			&& (is_par ? !(is_4bit && !nib_q) : (bit_q == 4'hF)))
			done_q <= 1'b1;
		else if (cmd_go)
			done_q <= 1'b0;
	end

	property p_serial_rw_low;
		@(posedge pclk) disable iff (!presetn)
		(!mode_q[2] && !$past(mode_q[2])) |=> !rw_pin;
	endproperty
	a_serial_rw_low: assert property (p_serial_rw_low) else $error("rw not low in serial"); // [R09]

	property p_cs_idle_high;
		@(posedge pclk) disable iff (!presetn)
		(state_q == ST_IDLE) ##1 (state_q == ST_IDLE) |-> cs_n;
	endproperty
	a_cs_idle_high: assert property (p_cs_idle_high) else $error("cs low while idle"); // [R12]

	property p_no_bad_mode;
		@(posedge pclk) disable iff (!presetn)
		host_if_strap_2 || !host_if_strap_0;
	endproperty
	a_no_bad_mode: assert property (p_no_bad_mode) else $error("invalid strap code"); // [R01]

	property p_straps_static;
		@(posedge pclk) disable iff (!presetn)
		busy && $past(busy) |-> $stable({host_if_strap_2, host_if_strap_1, host_if_strap_0});
	endproperty
	a_straps_static: assert property (p_straps_static) else $error("mode moved mid transfer"); // [R02]

	property p_68_rw_dir;
		@(posedge pclk) disable iff (!presetn)
		(is_par && !is_80 && strobe) |=> (rw_pin == rd_q);
	endproperty
	a_68_rw_dir: assert property (p_68_rw_dir) else $error("6800 direction wrong"); // [R07]

	property p_80_strobes;
		@(posedge pclk) disable iff (!presetn)
		(is_80 && $past(is_80)) |=> (rd_pin || rw_pin);
	endproperty
	a_80_strobes: assert property (p_80_strobes) else $error("both 8080 strobes low"); // [R06] [R08]

	property p_read_release;
		@(posedge pclk) disable iff (!presetn)
		(is_par && busy && rd_q) |=> (bus_oe_n == 8'hFF);
	endproperty
	a_read_release: assert property (p_read_release) else $error("bus driven on read"); // [R03]

	property p_dc_follows;
		@(posedge pclk) disable iff (!presetn)
		strobe |=> (data_command_select == dc_q);
	endproperty
	a_dc_follows: assert property (p_dc_follows) else $error("dc wrong in strobe"); // [R10]

	property p_reset_out;
		@(posedge pclk) disable iff (!presetn)
		rst_req_q |=> !module_reset_n;
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("module reset not held"); // [R11]
endmodule

// ===== src/dhi_pkg.sv
// shared constants for the display host interface controller
package dhi_pkg;
	localparam int unsigned CLK_HZ     = 50_000_000;
	localparam int unsigned NS_PER_S   = 1_000_000_000;
	// pin timing, ns, as printed (least times)
	localparam int unsigned T_CYCLE_NS = 400;
	localparam int unsigned T_RDLO_NS  = 250;
	localparam int unsigned T_RDHI_NS  = 155;
	localparam int unsigned T_WRLO_NS  = 50;
	localparam int unsigned T_WRHI_NS  = 55;
	localparam int unsigned T_AS_NS    = 13;
	// least times round up
	localparam int unsigned CYC_CYCLE = (T_CYCLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned CYC_RDLO  = (T_RDLO_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned CYC_RDHI  = (T_RDHI_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned CYC_WRLO  = (T_WRLO_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned CYC_WRHI  = (T_WRHI_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned CYC_AS    = (T_AS_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned CNT_W     = 8;

	// interface straps {s2,s1,s0}
	localparam logic [2:0] MODE_SERIAL = 3'h0;
	localparam logic [2:0] MODE_BAD1   = 3'h1;
	localparam logic [2:0] MODE_I2C    = 3'h2;
	localparam logic [2:0] MODE_BAD3   = 3'h3;
	localparam logic [2:0] MODE_M68_8  = 3'h4;
	localparam logic [2:0] MODE_M68_4  = 3'h5;
	localparam logic [2:0] MODE_I80_8  = 3'h6;
	localparam logic [2:0] MODE_I80_4  = 3'h7;

	// register map (byte addresses)
	localparam logic [11:0] REG_CTRL   = 12'h000;
	localparam logic [11:0] REG_CMD    = 12'h004;
	localparam logic [11:0] REG_STATUS = 12'h008;
	localparam logic [11:0] REG_RDATA  = 12'h00C;
	// CTRL fields
	localparam int unsigned CTRL_MODE_LSB = 0;
	localparam int unsigned CTRL_RST_BIT  = 4;
	localparam logic [2:0]  CTRL_MODE_RST = MODE_M68_8;
	// CMD fields
	localparam int unsigned CMD_DATA_LSB = 0;
	localparam int unsigned CMD_DC_BIT   = 8;
	localparam int unsigned CMD_RD_BIT   = 9;
	// STATUS fields
	localparam int unsigned ST_BUSY_BIT = 0;
	localparam int unsigned ST_BAD_BIT  = 1;
	localparam int unsigned ST_DONE_BIT = 2;
	localparam logic [31:0] SLV_ERR_NONE = 32'h0000_0000;
endpackage

// ===== src/dhi_phase_timer.sv
// down-counter that times one pin phase
module dhi_phase_timer
	import dhi_pkg::*;
#(
	parameter int unsigned W = CNT_W
)(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         load,
	input  wire logic [W-1:0] count,
	output logic              expired
);
	logic [W-1:0] cnt_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_q <= '0;
		else if (load)
			cnt_q <= count;
		else if (cnt_q != '0)
			cnt_q <= cnt_q - W'(1);
	end

	// no term from load here: callers build load from expired
	assign expired = (cnt_q == '0);
endmodule

// ===== testbench/dhi_dev.sv
// behavioural display module answering the host pins
module dhi_dev
	import dhi_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic [2:0] strap,
	input  wire logic [7:0] bus,
	input  wire logic       rd_pin,
	input  wire logic       rw_pin,
	input  wire logic       dc,
	input  wire logic       rst_n,
	input  wire logic       cs_n,
	input  wire logic [7:0] rd_byte,
	output logic      [7:0] dev_out,
	output logic            drv,
	output logic      [7:0] n_byte,
	output logic      [7:0] last_byte,
	output logic            last_dc,
	output logic      [7:0] n_bad
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       wide, ph, par, stb, stb_q, wr, sclk_q, dc_l;
	logic [7:0] lat, acc, held, cur, sh, contrast;
	logic [2:0] nbit;
	// pins sampled on the bench clock: checks setup, not hold
	assign par = !cs_n && rst_n && strap[2];
	assign stb = par && (strap[1] ? !(rd_pin && rw_pin) : rd_pin);
	assign wide = !strap[0];
	assign cur = wide ? rd_byte : (ph ? {rd_byte[3:0], 4'h0} : {rd_byte[7:4], 4'h0});
	assign drv = stb && rw_pin;
	// released bus shows the inverse of the last byte, never a stale match
	assign dev_out = drv ? cur : ~held;
	always @(posedge pclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			n_byte   <= 8'h00;
			ph       <= 1'b0;
			stb_q    <= 1'b0;
			sclk_q   <= 1'b0;
			n_bad    <= 8'h00;
			nbit     <= 3'h0;
			held     <= 8'h00;
			contrast <= 8'h7F;
		end
		else
		begin
			stb_q  <= stb;
			sclk_q <= bus[0];
			if (stb)
			begin
				lat  <= bus;
				wr   <= !rw_pin;
				dc_l <= dc;
			end
			if (drv)
				held <= cur;
			if (stb_q && !stb)
			begin
				ph  <= wide ? 1'b0 : !ph;
				acc <= lat;
				if (wr && (wide || ph))
				begin
					last_byte <= wide ? lat : {acc[7:4], lat[7:4]};
					last_dc   <= dc_l;
					n_byte    <= n_byte + 8'h01;
				end
			end
			if (strap != MODE_SERIAL || cs_n)
				nbit <= 3'h0;
			else if (bus[0] && !sclk_q)
			begin
				sh   <= {sh[6:0], bus[1]};
				nbit <= nbit + 3'h1;
				if (nbit == 3'h7)
				begin
					last_byte <= {sh[6:0], bus[1]};
					last_dc   <= dc;
					n_byte    <= n_byte + 8'h01;
				end
			end
			if (strap == MODE_SERIAL && !cs_n && rw_pin)
				n_bad <= n_bad + 8'h01;
		end
	end
endmodule

// ===== testbench/test_dhi_host.sv
// bench for the display host controller
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("ERROR %s expected %h seen %h", nm, ex, got); end end
module test_dhi_host
	import dhi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slv, drv, last_dc;
	logic        host_if_strap_0, host_if_strap_1, host_if_strap_2, rd_pin, rw_pin, cs_n;
	logic        data_command_select, module_reset_n;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	logic [7:0]  bus_in, bus_out, bus_oe_n, dev_out, rd_byte, n_byte, last_byte, n_bad;
	logic [2:0]  strp;
	int          n_mismatch, cmp_count;
	assign strp = {host_if_strap_2, host_if_strap_1, host_if_strap_0};
	assign bus_in = (bus_oe_n & dev_out) | (~bus_oe_n & bus_out);
	always #10 pclk = ~pclk;
	dhi_host u_dhi_host (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .host_if_strap_0, .host_if_strap_1, .host_if_strap_2, .bus_in,
		.bus_out, .bus_oe_n, .rd_pin, .rw_pin, .data_command_select, .module_reset_n, .cs_n);
	dhi_dev u_dhi_dev (.pclk, .strap(strp), .bus(bus_in), .rd_pin, .rw_pin,
		.dc(data_command_select), .rst_n(module_reset_n), .cs_n, .rd_byte, .dev_out, .drv,
		.n_byte, .last_byte, .last_dc, .n_bad);
	always @(posedge pclk)
		if (drv === 1'b1)
			`CHK("bus_oe_n on read", 8'hFF, bus_oe_n)
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1);
		`CHK("pready wait", 1, n)
		rv = prdata;
		slv = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		do
		begin
			apb(1'b0, REG_STATUS, 32'h0);
			n++;
		end
		while (rv[ST_BUSY_BIT] !== 1'b0 && n < 100);
		`CHK("busy", 1'b0, rv[ST_BUSY_BIT])
		if (rv[ST_BUSY_BIT] !== 1'b0)
			print_verdict();
	endtask
	task automatic t_reset();
		`CHK("cs_n", 1'b1, cs_n)
		`CHK("module_reset_n", 1'b0, module_reset_n)
		`CHK("straps", 3'h4, strp)
		`CHK("bus_oe_n", 8'hFF, bus_oe_n)
		apb(1'b0, REG_CTRL, 32'h0);
		`CHK("ctrl", 32'h0000_0014, rv)
		apb(1'b0, 12'h002, 32'h0);
		`CHK("pslverr", 1'b1, slv)
		apb(1'b1, REG_CTRL, 32'h0000_0004);
		repeat (2) @(posedge pclk);
		`CHK("module_reset_n", 1'b1, module_reset_n)
		$display("test reset done");
	endtask
	task automatic t_write(input logic [2:0] m, input logic [7:0] b, input logic d);
		logic [7:0] n0;
		apb(1'b1, REG_CTRL, {29'h0, m});
		repeat (2) @(posedge pclk);
		`CHK("straps", m, strp)
		n0 = n_byte;
		apb(1'b1, REG_CMD, {22'h0, 1'b0, d, b});
		// refused while busy: must not add a byte
		apb(1'b1, REG_CMD, {22'h0, 1'b0, !d, ~b});
		wait_idle();
		`CHK("done", 1'b1, rv[ST_DONE_BIT])
		`CHK("byte count", n0 + 8'h01, n_byte)
		`CHK("byte", b, last_byte)
		`CHK("dc", d, last_dc)
		`CHK("cs_n idle", 1'b1, cs_n)
		$display("test write mode %0d done", m);
	endtask
	task automatic t_read(input logic [2:0] m);
		logic [7:0] n0;
		rd_byte <= 8'h3C ^ {5'h0, m};
		n0 = n_byte;
		apb(1'b1, REG_CMD, 32'h0000_0300);
		wait_idle();
		apb(1'b0, REG_RDATA, 32'h0);
		`CHK("rdata", 8'h3C ^ {5'h0, m}, rv[7:0])
		`CHK("no write on read", n0, n_byte)
		$display("test read mode %0d done", m);
	endtask
	task automatic t_bad();
		logic [7:0] n0;
		for (int m = 1; m < 4; m += 2)
		begin
			apb(1'b1, REG_CTRL, 32'(m));
			apb(1'b0, REG_STATUS, 32'h0);
			`CHK("bad mode flag", 1'b1, rv[ST_BAD_BIT])
			`CHK("straps kept", MODE_SERIAL, strp)
		end
		n0 = n_byte;
		apb(1'b1, REG_CTRL, {29'h0, MODE_I2C});
		apb(1'b1, REG_CMD, 32'h0000_0155);
		apb(1'b0, REG_STATUS, 32'h0);
		`CHK("i2c busy", 1'b0, rv[ST_BUSY_BIT])
		`CHK("i2c straps", MODE_I2C, strp)
		`CHK("i2c no byte", n0, n_byte)
		$display("test bad modes done");
	endtask
	task automatic t_rst_req();
		apb(1'b1, REG_CTRL, 32'h0000_0014);
		apb(1'b1, REG_CMD, 32'h0000_0142);
		`CHK("module_reset_n", 1'b0, module_reset_n)
		`CHK("cs_n", 1'b1, cs_n)
		`CHK("device cleared", 8'h00, n_byte)
		apb(1'b0, REG_STATUS, 32'h0);
		`CHK("busy in reset", 1'b0, rv[ST_BUSY_BIT])
		t_write(MODE_M68_8, 8'h81, 1'b0);
		$display("test reset request done");
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		#200us;
		n_mismatch++;
		print_verdict();
	end
	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		rd_byte = 8'h00;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		for (int m = 4; m < 8; m++)
		begin
			t_write(m[2:0], 8'hA5 ^ 8'(m), 1'b1);
			t_write(m[2:0], 8'h3C, 1'b0);
			t_read(m[2:0]);
		end
		t_write(MODE_SERIAL, 8'h96, 1'b1);
		`CHK("serial rw low", 8'h00, n_bad)
		t_bad();
		t_rst_req();
		print_verdict();
	end
endmodule
